// ### rtl/tx_app_side_map.vh
`ifndef TX_APP_SIDE_MAP_VH
`define TX_APP_SIDE_MAP_VH

// Register offsets (byte addresses, one 32-bit word each)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ERR_ENABLE  8'h08
`define REG_PARAM0      8'h0c
`define REG_PARAM1      8'h10
`define REG_PARAM2      8'h14
`define REG_FRAME_LEAD  8'h18
`define REG_CMD_LANE0   8'h1c

// Control register fields
`define CTRL_LINK_EN    0
`define CTRL_SUBCLASS1  1
`define CTRL_CMD_WIDE   2
`define CTRL_OUT_PAUSE  3

// Status register fields: sticky bits, state and level
`define ST_SAMPLE_INV   0
`define ST_CMD_INV      1
`define ST_FIFO_OVF     2
`define ST_SYNC_REQ     3
`define ST_STATE_LSB    8
`define ST_LEVEL_LSB    12

// Parameter register fields
`define P0_LANES_LSB    0
`define P0_F_LSB        8
`define P0_M_LSB        16
`define P0_CS_LSB       24
`define P1_N_LSB        0
`define P1_NP_LSB       8
`define P1_S_LSB        16
`define P1_CF_LSB       24
`define P1_HD_BIT       31
`define P2_E_LSB        0
`define P2_TEST_LSB     8

// Reset values
`define CTRL_RESET      4'h0
`define ERR_EN_RESET    3'h7
`define PARAM0_RESET    32'h00_08_04_01
`define PARAM1_RESET    32'h00_01_10_10
`define PARAM2_RESET    12'h001
`define FRAME_LEAD_RST  8'h08

// Test select codes
`define TEST_NORMAL     4'h0
`define TEST_NO_SCRAM   4'h1

// Link cycles per multiblock: 32 blocks of 66 bits, two blocks per 132-bit word
`define MB_CYCLES       5'h10
`define SYNC_HEADER     2'b01

`endif

// ### rtl/tx_app_side.v
// How it works
// - Sample ready only in user-data phase; data taken same cycle.
// - Frame ready rises a programmed number of cycles before sample ready.
// - Commands per lane, big endian, lane 0 in top slice, MSB first.
// - Command width is 6 bits for CRC-12, 18 bits standalone.
// - Command ready only in user-data phase; application supplies valid commands then.
// - Pulse marks each multiblock start and each extended multiblock start.
// - Static link parameters exported as side-band outputs of documented widths.
// - Four-bit test select: 0000 normal, 0001 scrambler off, rest reserved.
// - Interrupt on any enabled error or any synchronisation request.
// - 132-bit per-lane loopback bus, lane 0 in lowest slice.
// - Block runs on the link clock, line rate over 132.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_app_side_map.vh"

module sample_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output reg  [AW:0]      level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   wire            push;
   wire            pop;
   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         level  <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         level <= level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module tx_app_side #(
   parameter LANES = 2,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire                 clk,
   input  wire                 rstn,
   input  wire [7:0]           reg_addr,
   input  wire [31:0]          reg_wdata,
   input  wire                 reg_write,
   input  wire                 reg_read,
   output reg  [31:0]          reg_rdata,
   input  wire [LANES*128-1:0] sample_in_data,
   input  wire                 sample_in_valid,
   output reg                  sample_in_ready,
   output reg                  link_frame_ready,
   input  wire [LANES*18-1:0]  lane_command_in,
   input  wire                 lane_command_valid,
   output reg                  lane_command_ready,
   input  wire                 system_reference_in,
   input  wire                 sync_request_in,
   output reg                  multiblock_start,
   output reg                  ext_multiblock_start,
   output reg  [3:0]           param_lane_count,
   output reg  [7:0]           param_octets_per_frame,
   output reg  [7:0]           param_converter_count,
   output reg  [1:0]           param_ctrl_bits_per_sample,
   output reg  [4:0]           param_resolution,
   output reg  [4:0]           param_bits_per_sample,
   output reg  [4:0]           param_samples_per_frame,
   output reg  [4:0]           param_ctrl_words_per_frame,
   output reg                  param_high_density,
   output reg  [7:0]           param_ext_multiblock_period,
   output reg  [3:0]           param_test_select,
   output reg                  tx_irq_out,
   output reg  [LANES*132-1:0] tx_to_rx_loop_bus
);
   localparam S_IDLE   = 2'd0;
   localparam S_SYSREF = 2'd1;
   localparam S_LEAD   = 2'd2;
   localparam S_USER   = 2'd3;

   reg  [3:0]           ctrl;
   reg  [2:0]           err_enable;
   reg  [3:0]           sticky;
   reg  [31:0]          param0;
   reg  [31:0]          param1;
   reg  [11:0]          param2;
   reg  [7:0]           frame_lead;
   reg  [1:0]           state;
   reg  [1:0]           next_state;
   reg  [7:0]           lead_cnt;
   reg  [4:0]           mb_cnt;
   reg  [7:0]           emb_cnt;
   reg                  sysref_q;
   reg                  sync_q;
   reg  [LANES*18-1:0]  lane_cmd;
   reg  [AW+1:0]        free_after;
   wire [AW:0]          level;
   wire                 fifo_in_ready;
   wire                 fifo_out_valid;
   wire [LANES*128-1:0] fifo_out_data;
   wire [LANES*18-1:0]  cmd_slices;
   wire                 sample_take;
   wire                 drain;
   wire                 sysref_rise;
   wire                 sync_rise;
   wire                 ext_multiblock_clock_restart;
   wire [3:0]           sticky_set;
   wire [3:0]           sticky_clr;

   ////////////////////////////////////////////////////////////////////////////////
   // Register port

   wire wr_status = reg_write & (reg_addr == `REG_STATUS);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl       <= `CTRL_RESET;
         err_enable <= `ERR_EN_RESET;
         param0     <= `PARAM0_RESET;
         param1     <= `PARAM1_RESET;
         param2     <= `PARAM2_RESET;
         frame_lead <= `FRAME_LEAD_RST;
      end else if (reg_write) begin
         case (reg_addr)
            `REG_CTRL:       ctrl       <= reg_wdata[3:0];
            `REG_ERR_ENABLE: err_enable <= reg_wdata[2:0];
            `REG_PARAM0:     param0     <= {6'h00, reg_wdata[25:0]};
            `REG_PARAM1:     param1     <= {reg_wdata[31], 2'h0, reg_wdata[28:24], 3'h0, reg_wdata[20:16],
                                            3'h0, reg_wdata[12:8], 3'h0, reg_wdata[4:0]};
            `REG_PARAM2:     param2     <= reg_wdata[11:0];
            `REG_FRAME_LEAD: frame_lead <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Unmapped offsets read as zero
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         reg_rdata <= 32'h0000_0000;
      else if (reg_read) begin
         case (reg_addr)
            `REG_CTRL:       reg_rdata <= {28'h0, ctrl};
            `REG_STATUS:     reg_rdata <= {{(32-`ST_LEVEL_LSB-AW-1){1'b0}}, level, 2'h0, state, 4'h0, sticky};
            `REG_ERR_ENABLE: reg_rdata <= {29'h0, err_enable};
            `REG_PARAM0:     reg_rdata <= param0;
            `REG_PARAM1:     reg_rdata <= param1;
            `REG_PARAM2:     reg_rdata <= {20'h0, param2};
            `REG_FRAME_LEAD: reg_rdata <= {24'h0, frame_lead};
            `REG_CMD_LANE0:  reg_rdata <= {14'h0, lane_cmd[LANES*18-1 -: 18]};
            default:         reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // Side-band link parameters, held stable for the transport layer
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         param_lane_count            <= 4'h0;
         param_octets_per_frame      <= 8'h00;
         param_converter_count       <= 8'h00;
         param_ctrl_bits_per_sample  <= 2'h0;
         param_resolution            <= 5'h00;
         param_bits_per_sample       <= 5'h00;
         param_samples_per_frame     <= 5'h00;
         param_ctrl_words_per_frame  <= 5'h00;
         param_high_density          <= 1'b0;
         param_ext_multiblock_period <= 8'h00;
         param_test_select           <= `TEST_NORMAL;
      end else begin
         param_lane_count            <= param0[`P0_LANES_LSB +: 4];
         param_octets_per_frame      <= param0[`P0_F_LSB +: 8];
         param_converter_count       <= param0[`P0_M_LSB +: 8];
         param_ctrl_bits_per_sample  <= param0[`P0_CS_LSB +: 2];
         param_resolution            <= param1[`P1_N_LSB +: 5];
         param_bits_per_sample       <= param1[`P1_NP_LSB +: 5];
         param_samples_per_frame     <= param1[`P1_S_LSB +: 5];
         param_ctrl_words_per_frame  <= param1[`P1_CF_LSB +: 5];
         param_high_density          <= param1[`P1_HD_BIT];
         param_ext_multiblock_period <= param2[`P2_E_LSB +: 8];
         param_test_select           <= param2[`P2_TEST_LSB +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link phase sequencing; clk is the link clock, line rate over 132

   assign sysref_rise  = system_reference_in & ~sysref_q;
   assign sync_rise    = sync_request_in & ~sync_q;
   // In subclass 0 the reference input is ignored entirely
   assign ext_multiblock_clock_restart = ctrl[`CTRL_SUBCLASS1] & sysref_rise;

   always @* begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (ctrl[`CTRL_LINK_EN])
               next_state = ctrl[`CTRL_SUBCLASS1] ? S_SYSREF : S_LEAD;
         end
         S_SYSREF: begin
            if (ext_multiblock_clock_restart)
               next_state = S_LEAD;
         end
         S_LEAD: begin
            if (lead_cnt == 8'h00)
               next_state = S_USER;
         end
         S_USER: ;
         default: next_state = S_IDLE;
      endcase
      // A resync request drops the link back to the start
      if (!ctrl[`CTRL_LINK_EN] || sync_rise)
         next_state = S_IDLE;
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state    <= S_IDLE;
         lead_cnt <= 8'h00;
         sysref_q <= 1'b0;
         sync_q   <= 1'b0;
      end else begin
         state    <= next_state;
         sysref_q <= system_reference_in;
         sync_q   <= sync_request_in;
         if (next_state == S_LEAD && state != S_LEAD)
            lead_cnt <= (frame_lead == 8'h00) ? 8'h00 : frame_lead - 8'h01;
         else if (lead_cnt != 8'h00)
            lead_cnt <= lead_cnt - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Multiblock and extended multiblock markers

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mb_cnt               <= 5'h00;
         emb_cnt              <= 8'h00;
         multiblock_start     <= 1'b0;
         ext_multiblock_start <= 1'b0;
      end else if (state == S_IDLE || ext_multiblock_clock_restart) begin
         mb_cnt               <= 5'h00;
         emb_cnt              <= 8'h00;
         multiblock_start     <= 1'b0;
         ext_multiblock_start <= 1'b0;
      end else begin
         mb_cnt           <= (mb_cnt == `MB_CYCLES - 5'h01) ? 5'h00 : mb_cnt + 5'h01;
         multiblock_start <= (mb_cnt == 5'h00);
         if (mb_cnt == `MB_CYCLES - 5'h01)
            emb_cnt <= (emb_cnt + 8'h01 >= param2[7:0]) ? 8'h00 : emb_cnt + 8'h01;
         ext_multiblock_start <= (mb_cnt == 5'h00) && (emb_cnt == 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sample and command sinks

   assign sample_take = sample_in_ready & sample_in_valid;
   assign drain       = (state == S_USER) & ~ctrl[`CTRL_OUT_PAUSE];

   // Room left next cycle; ready is registered so it stays one slot ahead
   always @* begin
      free_after = {1'b0, DEPTH[AW:0]} - {1'b0, level} - {{(AW+1){1'b0}}, sample_take}
                   + {{(AW+1){1'b0}}, drain & fifo_out_valid};
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sample_in_ready    <= 1'b0;
         lane_command_ready <= 1'b0;
         link_frame_ready   <= 1'b0;
      end else begin
         sample_in_ready    <= (next_state == S_USER) && (free_after != {(AW+2){1'b0}});
         lane_command_ready <= (next_state == S_USER);
         link_frame_ready   <= (next_state == S_LEAD) || (next_state == S_USER);
      end
   end

   sample_fifo #(
      .WIDTH (LANES*128),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (sample_take),
      .in_ready  (fifo_in_ready),
      .in_data   (sample_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (drain),
      .out_data  (fifo_out_data),
      .level     (level)
   );

   genvar i;
   generate
      for (i = 0; i < LANES; i = i + 1) begin : g_lane
         // Lane 0 sits in the top slice of the command bus, first bit at its MSB
         assign cmd_slices[(LANES-1-i)*18 +: 18] = ctrl[`CTRL_CMD_WIDE] ?
                                                  lane_command_in[(LANES-1-i)*18 +: 18] :
                                                  {12'h000, lane_command_in[(LANES-1-i)*6 +: 6]};
         // Lane 0 of the loopback bus is the lowest slice
         always @(posedge clk or negedge rstn) begin
            if (!rstn)
               tx_to_rx_loop_bus[i*132 +: 132] <= {132{1'b0}};
            else if (drain & fifo_out_valid)
               tx_to_rx_loop_bus[i*132 +: 132] <= {`SYNC_HEADER, fifo_out_data[(LANES-1-i)*128 + 64 +: 64],
                                                   `SYNC_HEADER, fifo_out_data[(LANES-1-i)*128 +: 64]};
         end
      end
   endgenerate

   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         lane_cmd <= {(LANES*18){1'b0}};
      else if (lane_command_ready & lane_command_valid)
         lane_cmd <= cmd_slices;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky errors and interrupt; a new event beats a clear in the same cycle

   assign sticky_set[`ST_SAMPLE_INV] = sample_in_ready & ~sample_in_valid;
   assign sticky_set[`ST_CMD_INV]    = lane_command_ready & ~lane_command_valid;
   // The sink cannot push back, so a full buffer under a valid sample is lost data
   assign sticky_set[`ST_FIFO_OVF]   = sample_take & ~fifo_in_ready;
   assign sticky_set[`ST_SYNC_REQ]   = sync_rise;
   assign sticky_clr                 = wr_status ? reg_wdata[3:0] : 4'h0;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sticky     <= 4'h0;
         tx_irq_out <= 1'b0;
      end else begin
         sticky     <= (sticky & ~sticky_clr) | sticky_set;
         tx_irq_out <= |(((sticky & ~sticky_clr) | sticky_set) & {1'b1, err_enable});
      end
   end
endmodule
`default_nettype wire

// ### test/tx_app_side_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tx_app_side_chk #(
   parameter LANES = 2
) (
   input wire logic                 clk,
   input wire logic                 rstn,
   input wire logic                 reg_write,
   input wire logic                 sync_request_in,
   input wire logic                 sample_in_ready,
   input wire logic                 link_frame_ready,
   input wire logic                 lane_command_ready,
   input wire logic                 multiblock_start,
   input wire logic                 ext_multiblock_start,
   input wire logic [7:0]           param_octets_per_frame,
   input wire logic                 tx_irq_out,
   input wire logic [LANES*132-1:0] tx_to_rx_loop_bus
);
   localparam W = LANES*132;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_ready_in_user; sample_in_ready |-> link_frame_ready && lane_command_ready; endproperty
   a_ready_in_user: assert property (p_ready_in_user) else $error("sample ready outside user phase");
   property p_cmd_user; lane_command_ready |-> link_frame_ready; endproperty
   a_cmd_user: assert property (p_cmd_user) else $error("command ready without frame ready");
   property p_lead; $rose(sample_in_ready) |-> $past(link_frame_ready); endproperty
   a_lead: assert property (p_lead) else $error("frame ready gave no lead");
   property p_ext_on_mb; ext_multiblock_start |-> multiblock_start; endproperty
   a_ext_on_mb: assert property (p_ext_on_mb) else $error("extended marker off a multiblock edge");
   // Only judged while the link stays up across the whole period
   property p_mb_period;
      multiblock_start ##1 link_frame_ready[*8] ##1 link_frame_ready[*8] |-> multiblock_start;
   endproperty
   a_mb_period: assert property (p_mb_period) else $error("multiblock marker period wrong");
   property p_sync_irq; $rose(sync_request_in) |-> ##[1:3] tx_irq_out; endproperty
   a_sync_irq: assert property (p_sync_irq) else $error("sync request gave no interrupt");
   property p_loop_hdr;
      $changed(tx_to_rx_loop_bus) |-> tx_to_rx_loop_bus == '0 || (tx_to_rx_loop_bus[131:130] == 2'b01 &&
         tx_to_rx_loop_bus[65:64] == 2'b01 && tx_to_rx_loop_bus[W-1:W-2] == 2'b01);
   endproperty
   a_loop_hdr: assert property (p_loop_hdr) else $error("loopback block header wrong");
   property p_param_write;
      $changed(param_octets_per_frame) |-> $past(reg_write) || $past(reg_write, 2) || !$past(rstn, 2)
         || !$past(rstn, 3);
   endproperty
   a_param_write: assert property (p_param_write) else $error("parameter output moved without write");
endmodule

bind tx_app_side tx_app_side_chk #(.LANES(LANES)) chk_i (.clk(clk), .rstn(rstn), .reg_write(reg_write),
   .sync_request_in(sync_request_in), .sample_in_ready(sample_in_ready), .link_frame_ready(link_frame_ready),
   .lane_command_ready(lane_command_ready), .multiblock_start(multiblock_start),
   .ext_multiblock_start(ext_multiblock_start), .param_octets_per_frame(param_octets_per_frame),
   .tx_irq_out(tx_irq_out), .tx_to_rx_loop_bus(tx_to_rx_loop_bus));
`default_nettype wire

// ### test/app_model.sv
`timescale 1ns/1ps
`default_nettype none
module app_model (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         sample_in_ready,
   input  wire logic         lane_command_ready,
   input  wire logic         drop_valid,
   input  wire logic         cmd_wide,
   output var  logic [255:0] sample_in_data,
   output var  logic         sample_in_valid,
   output var  logic [35:0]  lane_command_in,
   output var  logic         lane_command_valid
);
   logic [55:0]  k;
   logic [255:0] word;
   logic [35:0]  cmd;
   // Word number is carried in every half so the far end can spot loss
   assign word = {8'h0a, k, 8'h0b, k, 8'h1a, k, 8'h1b, k};
   assign cmd = cmd_wide ? {18'h25a5a, 18'h1c3c3} : {24'habcdef, 6'h2d, 6'h13};
   // Zero ready latency: data follows ready in the same cycle; inverted when not asked
   assign sample_in_valid = sample_in_ready & !drop_valid;
   assign sample_in_data = sample_in_ready ? word : ~word;
   assign lane_command_valid = lane_command_ready;
   assign lane_command_in = lane_command_ready ? cmd : ~cmd;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) k <= 56'h0;
      else if (sample_in_ready && sample_in_valid) k <= k + 56'h1;
   end
endmodule
`default_nettype wire

// ### test/tb_tx_app_side.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_app_side_map.vh"
module tb_tx_app_side;
   logic         clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, system_reference_in = 1'b0;
   logic         sync_request_in = 1'b0, drop_valid = 1'b0, cmd_wide = 1'b0, seen_any = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wdata = 32'h0, reg_rdata, d;
   logic [255:0] sample_in_data;
   logic [35:0]  lane_command_in;
   logic [263:0] tx_to_rx_loop_bus, prev_bus = '0;
   logic [55:0]  last_k;
   logic         sample_in_valid, sample_in_ready, link_frame_ready, lane_command_valid, lane_command_ready;
   logic         multiblock_start, ext_multiblock_start, param_high_density, tx_irq_out;
   logic [3:0]   param_lane_count, param_test_select;
   logic [7:0]   param_octets_per_frame, param_converter_count, param_ext_multiblock_period;
   logic [1:0]   param_ctrl_bits_per_sample;
   logic [4:0]   param_resolution, param_bits_per_sample, param_samples_per_frame, param_ctrl_words_per_frame;
   int           num_errors = 0, total_checks = 0, n, m, e;

   always #4 clk = ~clk;

   tx_app_side #(.LANES(2)) tx_app_side_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_in_data(sample_in_data),
      .sample_in_valid(sample_in_valid), .sample_in_ready(sample_in_ready), .link_frame_ready(link_frame_ready),
      .lane_command_in(lane_command_in), .lane_command_valid(lane_command_valid),
      .lane_command_ready(lane_command_ready), .system_reference_in(system_reference_in),
      .sync_request_in(sync_request_in),
      .multiblock_start(multiblock_start), .ext_multiblock_start(ext_multiblock_start),
      .param_lane_count(param_lane_count), .param_octets_per_frame(param_octets_per_frame),
      .param_converter_count(param_converter_count), .param_ctrl_bits_per_sample(param_ctrl_bits_per_sample),
      .param_resolution(param_resolution), .param_bits_per_sample(param_bits_per_sample),
      .param_samples_per_frame(param_samples_per_frame), .param_ctrl_words_per_frame(param_ctrl_words_per_frame),
      .param_high_density(param_high_density), .param_ext_multiblock_period(param_ext_multiblock_period),
      .param_test_select(param_test_select), .tx_irq_out(tx_irq_out), .tx_to_rx_loop_bus(tx_to_rx_loop_bus));

   app_model app_model_i (.clk(clk), .rstn(rstn), .sample_in_ready(sample_in_ready),
      .lane_command_ready(lane_command_ready), .drop_valid(drop_valid), .cmd_wide(cmd_wide),
      .sample_in_data(sample_in_data), .sample_in_valid(sample_in_valid), .lane_command_in(lane_command_in),
      .lane_command_valid(lane_command_valid));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [263:0] seen, input logic [263:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) begin reg_write <= 1'b1; reg_addr <= a; reg_wdata <= v; end
      @(posedge clk) reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk) begin reg_read <= 1'b1; reg_addr <= a; end
      @(posedge clk) reg_read <= 1'b0;
      @(negedge clk) d = reg_rdata;
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [263:0] loop_of(input logic [55:0] k);
      return {2'b01, 8'h1a, k, 2'b01, 8'h1b, k, 2'b01, 8'h0a, k, 2'b01, 8'h0b, k};
   endfunction

   // Each new loopback word must be the next sample, lane 0 in the low slice
   always @(negedge clk) begin
      if (rstn && tx_to_rx_loop_bus !== prev_bus && tx_to_rx_loop_bus !== '0) begin
         check(tx_to_rx_loop_bus, loop_of(tx_to_rx_loop_bus[121:66]));
         if (seen_any) check(tx_to_rx_loop_bus[121:66], last_k + 56'h1);
         last_k = tx_to_rx_loop_bus[121:66];
         seen_any = 1'b1;
      end
      prev_bus = tx_to_rx_loop_bus;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(`REG_PARAM0); check(d, `PARAM0_RESET);
      rd(`REG_PARAM1); check(d, `PARAM1_RESET);
      rd(`REG_ERR_ENABLE); check(d, `ERR_EN_RESET);
      rd(8'h40); check(d, 32'h0);
      check({param_lane_count, param_octets_per_frame, param_converter_count}, 20'h10408);
      check({param_resolution, param_samples_per_frame, param_ext_multiblock_period}, 18'h20101);
      check(param_test_select, `TEST_NORMAL);
   endtask
   task t_params;
      wr(`REG_PARAM0, 32'h02a55a03);
      wr(`REG_PARAM1, 32'h9b1c0d1e);
      repeat (2) @(negedge clk);
      check({param_lane_count, param_octets_per_frame, param_converter_count}, 20'h35aa5);
      check({param_ctrl_bits_per_sample, param_high_density, param_ctrl_words_per_frame}, 8'hbb);
      check({param_resolution, param_bits_per_sample, param_samples_per_frame}, 15'h79bc);
      for (int i = 0; i < 2; i++) begin
         wr(`REG_PARAM2, {20'h0, i[3:0], 8'h02});
         repeat (2) @(negedge clk);
         check({param_test_select, param_ext_multiblock_period}, {i[3:0], 8'h02});
      end
   endtask
   task t_link;
      @(posedge clk) cmd_wide <= 1'b1;
      wr(`REG_FRAME_LEAD, 32'h3);
      wr(`REG_CTRL, 32'h5);
      for (n = 0; n < 50 && link_frame_ready !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 50 && sample_in_ready !== 1'b1; n++) @(negedge clk);
      check(n, 3);
      check(lane_command_ready, 1'b1);
      repeat (8) @(negedge clk);
      rd(`REG_CMD_LANE0); check(d, 32'h25a5a);
      @(posedge clk) cmd_wide <= 1'b0;
      wr(`REG_CTRL, 32'h1);
      repeat (4) @(negedge clk);
      rd(`REG_CMD_LANE0); check(d, 32'h2d);
   endtask
   task t_markers;
      repeat (32) @(negedge clk);
      m = 0;
      e = 0;
      repeat (96) @(negedge clk) begin m += multiblock_start; e += ext_multiblock_start; end
      check({m[7:0], e[7:0]}, 16'h0603);
   endtask
   // Holding the drain stands in for a stalled far side
   task t_fifo;
      wr(`REG_CTRL, 32'h9);
      for (n = 0; n < 20 && sample_in_ready !== 1'b0; n++) @(negedge clk);
      repeat (5) @(negedge clk);
      check(sample_in_ready, 1'b0);
      rd(`REG_STATUS); check({d[`ST_FIFO_OVF], d[14:12]}, 4'h4);
      wr(`REG_CTRL, 32'h1);
      for (n = 0; n < 20 && sample_in_ready !== 1'b1; n++) @(negedge clk);
      check(sample_in_ready, 1'b1);
   endtask
   // Subclass 1: the link waits for the reference edge before its lead phase
   task t_sysref;
      wr(`REG_CTRL, 32'h0);
      wr(`REG_CTRL, 32'h3);
      repeat (4) @(negedge clk);
      rd(`REG_STATUS); check({link_frame_ready, d[9:8]}, 3'h1);
      @(posedge clk) system_reference_in <= 1'b1;
      for (n = 0; n < 5 && link_frame_ready !== 1'b1; n++) @(negedge clk);
      check(n, 2);
      @(posedge clk) system_reference_in <= 1'b0;
      wr(`REG_CTRL, 32'h1);
   endtask
   task t_irq;
      wr(`REG_ERR_ENABLE, 32'h0);
      @(posedge clk) drop_valid <= 1'b1;
      @(posedge clk) drop_valid <= 1'b0;
      repeat (3) @(negedge clk);
      check(tx_irq_out, 1'b0);
      rd(`REG_STATUS); check(d[`ST_SAMPLE_INV], 1'b1);
      wr(`REG_ERR_ENABLE, 32'h1);
      repeat (2) @(negedge clk);
      check(tx_irq_out, 1'b1);
      wr(`REG_STATUS, 32'h1);
      repeat (2) @(negedge clk);
      check(tx_irq_out, 1'b0);
      seen_any = 1'b0;
      @(posedge clk) sync_request_in <= 1'b1;
      for (n = 0; n < 5 && tx_irq_out !== 1'b1; n++) @(negedge clk);
      check(tx_irq_out, 1'b1);
      @(posedge clk) sync_request_in <= 1'b0;
      wr(`REG_STATUS, 32'h8);
      repeat (2) @(negedge clk);
      check(tx_irq_out, 1'b0);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_params;
      t_link;
      t_markers;
      t_fifo;
      t_sysref;
      t_irq;
      end_of_test;
   end
   initial begin
      #200000;
      num_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
